// file: verilog/isc_pkg.sv
// Constants and types for the instruction sequencer core
`default_nettype none
package isc_pkg;
  // Widths
  localparam int PC_W = 10;
  localparam int IW   = 14;
  localparam int DW   = 8;
  localparam int DA_W = 5;
  // Vectors and reset values
  localparam logic [PC_W-1:0] RESET_VEC = 10'h000;
  localparam logic [PC_W-1:0] IRQ_VEC   = 10'h004;
  localparam logic [DW-1:0]   ACC_RST   = 8'h00;
  localparam logic [DW-1:0]   PTR_RST   = 8'h00;
  localparam logic [3:0]      STAT_RST  = 4'h0;
  localparam logic            RUN_RST   = 1'b1;
  localparam logic            IE_RST    = 1'b0;
  // Bus register offsets and fields
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PC_OFF   = 8'h04;
  localparam logic [7:0] CORE_OFF = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_IE  = 1;
  localparam int CTRL_IRQ = 2;
  localparam int CORE_ST  = 8;
  // Status flag positions
  localparam int ST_C  = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  // Data space map
  localparam logic [DA_W-1:0] DA_IND  = 5'h00;
  localparam logic [DA_W-1:0] DA_PTR  = 5'h01;
  localparam logic [DA_W-1:0] DA_PCL  = 5'h02;
  localparam logic [DA_W-1:0] DA_STAT = 5'h03;
  localparam logic [DA_W-1:0] DA_ACC  = 5'h04;
  // Instruction fields
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 11;
  localparam int OP_HI  = 10;
  localparam int OP_LO  = 6;
  localparam int DST    = 5;
  localparam int ADR_HI = 4;
  localparam int SK_HI  = 10;
  localparam int SK_LO  = 8;
  // Instruction classes
  localparam logic [2:0] CL_ALU  = 3'h0;
  localparam logic [2:0] CL_SKIP = 3'h1;
  localparam logic [2:0] CL_IMM  = 3'h2;
  localparam logic [2:0] CL_MISC = 3'h3;
  localparam logic [2:0] CL_JMP  = 3'h4;
  localparam logic [2:0] CL_CALL = 3'h5;
  // ALU operations
  localparam logic [4:0] OP_ADD = 5'h00;
  localparam logic [4:0] OP_ADC = 5'h01;
  localparam logic [4:0] OP_SUB = 5'h02;
  localparam logic [4:0] OP_SBC = 5'h03;
  localparam logic [4:0] OP_AND = 5'h04;
  localparam logic [4:0] OP_OR  = 5'h05;
  localparam logic [4:0] OP_XOR = 5'h06;
  localparam logic [4:0] OP_CPL = 5'h07;
  localparam logic [4:0] OP_RR  = 5'h08;
  localparam logic [4:0] OP_RRC = 5'h09;
  localparam logic [4:0] OP_RL  = 5'h0A;
  localparam logic [4:0] OP_RLC = 5'h0B;
  localparam logic [4:0] OP_INC = 5'h0C;
  localparam logic [4:0] OP_DEC = 5'h0D;
  localparam logic [4:0] OP_DAA = 5'h0E;
  localparam logic [4:0] OP_LD  = 5'h0F;
  localparam logic [4:0] OP_ST  = 5'h10;
  // Skip kinds and misc codes
  localparam logic [2:0] SK_SZ   = 3'h0;
  localparam logic [2:0] SK_SNZ  = 3'h1;
  localparam logic [2:0] SK_SZA  = 3'h2;
  localparam logic [2:0] SK_SIZ  = 3'h3;
  localparam logic [2:0] SK_SDZ  = 3'h4;
  localparam logic [2:0] SK_SIZA = 3'h5;
  localparam logic [2:0] SK_SDZA = 3'h6;
  localparam logic [2:0] MI_RET  = 3'h1;
  localparam logic [2:0] MI_RETURN_FROM_INTERRUPT = 3'h2;
  localparam logic [IW-1:0] NOP_WORD = 14'h1800;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } isc_phase_e;
endpackage : isc_pkg
`default_nettype wire

// file: verilog/isc_core.sv
// Instruction sequencer core with AXI4-Lite control
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module isc_core #(
  parameter int DM_DEPTH  = 32,
  parameter int STK_DEPTH = 2,
  parameter int AXI_AW    = 8
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // AXI4-Lite write channels
  input  wire logic [AXI_AW-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [AXI_AW-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Program memory
  output logic [isc_pkg::PC_W-1:0]     pm_addr,
  input  wire logic [isc_pkg::IW-1:0]  pm_data,
  // Phase clocks
  output logic [3:0]                   instruction_phase_clocks
);
  import isc_pkg::*;

  localparam int SPW = $clog2(STK_DEPTH);
  localparam logic [SPW:0] STK_FULL = (SPW+1)'(STK_DEPTH);

  if (DM_DEPTH < 8 || DM_DEPTH > 32) begin : g_bad_dm
    $error("DM_DEPTH must lie in 8..32");
  end
  if (STK_DEPTH < 2 || (STK_DEPTH & (STK_DEPTH - 1)) != 0) begin : g_bad_stk
    $error("STK_DEPTH must be a power of two");
  end
  if (AXI_AW < 8 || AXI_AW > 32) begin : g_bad_aw
    $error("AXI_AW must lie in 8..32");
  end

  isc_phase_e       phase_r;
  logic             t1;
  logic             t4;
  logic             run_r;
  logic             ie_r;
  logic             irq_r;
  logic [PC_W-1:0]  pc_r;
  logic [PC_W-1:0]  pc_ret;
  logic [IW-1:0]    fetch_r;
  logic [IW-1:0]    ex_r;
  logic             dummy_r;
  logic [DW-1:0]    acc_r;
  logic [DW-1:0]    ptr_r;
  logic [3:0]       stat_r;
  logic [DW-1:0]    dm_r [DM_DEPTH];
  logic [PC_W-1:0]  stk_r [STK_DEPTH];
  logic [SPW-1:0]   sp_r;
  logic [SPW:0]     cnt_r;
  logic             full;
  logic [PC_W-1:0]  top;
  logic [2:0]       cls;
  logic [2:0]       sk;
  logic [4:0]       op;
  logic             to_mem;
  logic [DA_W-1:0]  adr;
  logic [DA_W-1:0]  ea;
  logic [DW-1:0]    m;
  logic [DW-1:0]    b;
  logic             cin;
  logic [8:0]       sum;
  logic [4:0]       half;
  logic [8:0]       dsum;
  logic             lo6;
  logic             hi6;
  logic             zu;
  logic [DW-1:0]    res;
  logic [3:0]       st_nxt;
  logic [DW-1:0]    sval;
  logic             cond;
  logic             wr_en;
  logic [DW-1:0]    wv;
  logic             acc_we;
  logic [DW-1:0]    acc_dat;
  logic             flag_we;
  logic             br;
  logic [PC_W-1:0]  tgt;
  logic             push;
  logic             pop;
  logic             skip;
  logic             return_from_interrupt;
  logic             take;
  logic             aw_go;
  logic             ar_go;
  logic             ctrl_wr;
  logic [2:0]       wsel;
  logic [2:0]       rsel;
  logic [31:0]      rd_val;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [1:0]       rresp_r;
  logic [31:0]      rdata_r;

  // Register decode, one-hot {core, pc, ctrl}
  function automatic logic [2:0] reg_dec(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] w;
    w = {a[AXI_AW-1:2], 2'b00};
    reg_dec = {w == AXI_AW'(CORE_OFF), w == AXI_AW'(PC_OFF), w == AXI_AW'(CTRL_OFF)};
  endfunction : reg_dec

  // Phase sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= PH_T1;
    end else if (run_r) begin
      case (phase_r)
        PH_T1:   phase_r <= PH_T2;
        PH_T2:   phase_r <= PH_T3;
        PH_T3:   phase_r <= PH_T4;
        PH_T4:   phase_r <= PH_T1;
        default: phase_r <= PH_T1;
      endcase
    end
  end

  assign t1 = run_r && (phase_r == PH_T1);
  assign t4 = run_r && (phase_r == PH_T4);
  assign instruction_phase_clocks = phase_r;
  assign pm_addr = pc_r;

  // Decode
  assign cls    = ex_r[CLS_HI:CLS_LO];
  assign op     = ex_r[OP_HI:OP_LO];
  assign sk     = ex_r[SK_HI:SK_LO];
  assign to_mem = ex_r[DST];
  assign adr    = ex_r[ADR_HI:0];
  assign ea     = (adr == DA_IND) ? ptr_r[DA_W-1:0] : adr;
  assign pc_ret = pc_r - PC_W'(1);
  assign full   = (cnt_r == STK_FULL);
  assign top    = stk_r[sp_r - SPW'(1)];

  // Operand read from data space
  always_comb begin
    case (ea)
      DA_IND:  m = 8'h00;
      DA_PTR:  m = ptr_r;
      DA_PCL:  m = pc_ret[DW-1:0];
      DA_STAT: m = {4'h0, stat_r};
      DA_ACC:  m = acc_r;
      default: m = (32'(ea) < DM_DEPTH) ? dm_r[ea] : 8'h00;
    endcase
  end

  // ALU
  always_comb begin
    b      = (op == OP_SUB || op == OP_SBC) ? ~m : m;
    cin    = (op == OP_ADC || op == OP_SBC) ? stat_r[ST_C] : (op == OP_SUB);
    sum    = {1'b0, acc_r} + {1'b0, b} + {8'h00, cin};
    half   = {1'b0, acc_r[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    lo6    = (acc_r[3:0] > 4'h9) || stat_r[ST_AC];
    dsum   = {1'b0, acc_r} + (lo6 ? 9'h006 : 9'h000);
    hi6    = (dsum[7:4] > 4'h9) || stat_r[ST_C] || dsum[8];
    res    = sum[DW-1:0];
    st_nxt = stat_r;
    zu     = 1'b1;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        st_nxt[ST_C]  = sum[8];
        st_nxt[ST_AC] = half[4];
        st_nxt[ST_OV] = (acc_r[7] == b[7]) && (res[7] != acc_r[7]);
      end
      OP_AND: res = acc_r & m;
      OP_OR:  res = acc_r | m;
      OP_XOR: res = acc_r ^ m;
      OP_CPL: res = ~m;
      OP_RR: begin
        res = {m[0], m[7:1]};
        zu  = 1'b0;
      end
      OP_RRC: begin
        res          = {stat_r[ST_C], m[7:1]};
        st_nxt[ST_C] = m[0];
        zu           = 1'b0;
      end
      OP_RL: begin
        res = {m[6:0], m[7]};
        zu  = 1'b0;
      end
      OP_RLC: begin
        res          = {m[6:0], stat_r[ST_C]};
        st_nxt[ST_C] = m[7];
        zu           = 1'b0;
      end
      OP_INC: res = m + 8'h01;
      OP_DEC: res = m - 8'h01;
      OP_DAA: begin
        res          = dsum[DW-1:0] + (hi6 ? 8'h60 : 8'h00);
        st_nxt[ST_C] = hi6;
        zu           = 1'b0;
      end
      OP_LD: begin
        res = m;
        zu  = 1'b0;
      end
      OP_ST: begin
        res = acc_r;
        zu  = 1'b0;
      end
      default: begin
        res = m;
        zu  = 1'b0;
      end
    endcase
    if (zu) begin
      st_nxt[ST_Z] = (res == 8'h00);
    end
  end

  // Skip evaluation
  always_comb begin
    case (sk)
      SK_SIZ, SK_SIZA: sval = m + 8'h01;
      SK_SDZ, SK_SDZA: sval = m - 8'h01;
      default:         sval = m;
    endcase
    cond = (sk == SK_SNZ) ? (m != 8'h00) : (sval == 8'h00);
  end

  // Execute control
  always_comb begin
    wr_en   = 1'b0;
    wv      = res;
    acc_we  = 1'b0;
    acc_dat = res;
    flag_we = 1'b0;
    br      = 1'b0;
    tgt     = ex_r[PC_W-1:0];
    push    = 1'b0;
    pop     = 1'b0;
    skip    = 1'b0;
    return_from_interrupt    = 1'b0;
    case (cls)
      CL_ALU: begin
        flag_we = 1'b1;
        wr_en   = to_mem;
        acc_we  = !to_mem;
      end
      CL_SKIP: begin
        skip    = cond;
        wv      = sval;
        acc_dat = sval;
        wr_en   = (sk == SK_SIZ) || (sk == SK_SDZ);
        acc_we  = (sk == SK_SZA) || (sk == SK_SIZA) || (sk == SK_SDZA);
      end
      CL_IMM: begin
        acc_we  = 1'b1;
        acc_dat = ex_r[DW-1:0];
      end
      CL_MISC: begin
        if (sk == MI_RET || sk == MI_RETURN_FROM_INTERRUPT) begin
          pop  = 1'b1;
          br   = 1'b1;
          tgt  = top;
          return_from_interrupt = (sk == MI_RETURN_FROM_INTERRUPT);
        end
      end
      CL_JMP:  br = 1'b1;
      CL_CALL: begin
        br   = 1'b1;
        push = 1'b1;
      end
      default: ;
    endcase
    if (wr_en && ea == DA_PCL) begin
      br  = 1'b1;
      tgt = {pc_ret[PC_W-1:DW], wv};
    end
  end

  assign take = irq_r && ie_r && !full && !br && !skip;

  // Fetch and execute pipeline
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_r    <= RESET_VEC;
      fetch_r <= NOP_WORD;
      ex_r    <= NOP_WORD;
      dummy_r <= 1'b0;
    end else if (t1) begin
      ex_r    <= dummy_r ? NOP_WORD : fetch_r;
      fetch_r <= pm_data;
      pc_r    <= pc_r + PC_W'(1);
      dummy_r <= 1'b0;
    end else if (t4 && (br || skip || take)) begin
      if (take) begin
        pc_r <= IRQ_VEC;
      end else if (br) begin
        pc_r <= tgt;
      end
      dummy_r <= 1'b1;
    end
  end

  // Return stack
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_r  <= '0;
      cnt_r <= '0;
    end else if (t4) begin
      if (push || take) begin
        stk_r[sp_r] <= pc_ret;
        sp_r        <= sp_r + SPW'(1);
        if (!full) begin
          cnt_r <= cnt_r + (SPW+1)'(1);
        end
      end else if (pop) begin
        sp_r <= sp_r - SPW'(1);
        if (cnt_r != '0) begin
          cnt_r <= cnt_r - (SPW+1)'(1);
        end
      end
    end
  end

  // Accumulator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_r <= ACC_RST;
    end else if (t4 && acc_we) begin
      acc_r <= acc_dat;
    end else if (t4 && wr_en && ea == DA_ACC) begin
      acc_r <= wv;
    end
  end

  // Status and pointer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_r <= STAT_RST;
      ptr_r  <= PTR_RST;
    end else if (t4) begin
      if (wr_en && ea == DA_STAT) begin
        stat_r <= wv[3:0];
      end else if (flag_we) begin
        stat_r <= st_nxt;
      end
      if (wr_en && ea == DA_PTR) begin
        ptr_r <= wv;
      end
    end
  end

  // General data registers
  always_ff @(posedge clk) begin
    if (t4 && wr_en && ea > DA_ACC && 32'(ea) < DM_DEPTH) begin
      dm_r[ea] <= wv;
    end
  end

  // Bus handshakes
  assign aw_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_awready = aw_go;
  assign s_axi_wready  = aw_go;
  assign ar_go         = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wsel          = reg_dec(s_axi_awaddr);
  assign rsel          = reg_dec(s_axi_araddr);
  assign ctrl_wr       = aw_go && wsel[0] && s_axi_wstrb[0];

  // Control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_r <= RUN_RST;
      ie_r  <= IE_RST;
      irq_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        run_r <= s_axi_wdata[CTRL_RUN];
      end
      irq_r <= (irq_r && !(t4 && take)) || (ctrl_wr && s_axi_wdata[CTRL_IRQ]);
      if (ctrl_wr) begin
        ie_r <= s_axi_wdata[CTRL_IE];
      end else if (t4 && take) begin
        ie_r <= 1'b0;
      end else if (t4 && return_from_interrupt) begin
        ie_r <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (aw_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rsel[0]) begin
      rd_val[CTRL_RUN] = run_r;
      rd_val[CTRL_IE]  = ie_r;
      rd_val[CTRL_IRQ] = irq_r;
    end
    if (rsel[1]) begin
      rd_val[PC_W-1:0] = pc_r;
    end
    if (rsel[2]) begin
      rd_val[DW-1:0]       = acc_r;
      rd_val[CORE_ST +: 4] = stat_r;
    end
  end

  // Read response
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= rd_val;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

endmodule : isc_core
`default_nettype wire

// file: verif/isc_pmem_model.sv
// Program memory model: 1K by 14 word array with combinational read
`timescale 1ns/1ps
`default_nettype none
module isc_pmem_model (
  // Fetch port
  input  wire logic [isc_pkg::PC_W-1:0] pm_addr,
  output logic      [isc_pkg::IW-1:0]   pm_data
);
  import isc_pkg::*;
  logic [IW-1:0] mem [0:1023];
  assign pm_data = mem[pm_addr];
endmodule : isc_pmem_model
`default_nettype wire

// file: verif/isc_core_checker.sv
// Port-level assertions for the instruction sequencer core
`timescale 1ns/1ps
`default_nettype none
module isc_core_checker #(
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      nrst,
  // Register bus
  input wire logic [AXI_AW-1:0]         s_axi_awaddr,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_awready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic [AXI_AW-1:0]         s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic                      s_axi_rvalid,
  // Fetch side and phases
  input wire logic [isc_pkg::PC_W-1:0]  pm_addr,
  input wire logic [3:0]                instruction_phase_clocks
);
  import isc_pkg::*;
  logic [3:0] ph;
  assign ph = instruction_phase_clocks;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_phase_onehot: assert property ($onehot(ph))
    else $error("phase clocks not one-hot");
  a_phase_order: assert property (##1 ($stable(ph) ||
    ph == {$past(ph[2:0]), $past(ph[3])})) else $error("phase out of order");
  a_fetch_step: assert property (ph == 4'h1 ##1 ph == 4'h2 |->
    pm_addr == $past(pm_addr) + 10'h1) else $error("counter did not step at fetch");
  a_addr_hold: assert property ((ph == 4'h2 || ph == 4'h4) |=> $stable(pm_addr))
    else $error("counter moved in mid cycle");
  a_reset_load: assert property ($rose(nrst) |->
    pm_addr == RESET_VEC && ph == 4'h1) else $error("reset vector not loaded");
  a_pc_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] == 6'h01 |=> s_axi_rvalid && s_axi_rdata[31:10] == 22'h0)
    else $error("counter read wider than 10 bits");
  a_pc_write: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready &&
    s_axi_awaddr[7:2] == 6'h01 |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("counter write not answered okay");
  a_no_stack_rd: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] == 6'h03 |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule : isc_core_checker
bind isc_core isc_core_checker #(.AXI_AW(AXI_AW)) isc_core_checker_i (.clk, .nrst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .pm_addr, .instruction_phase_clocks);
`default_nettype wire

// file: verif/isc_core_tb.sv
// Self-checking testbench for the instruction sequencer core
`timescale 1ns/1ps
`default_nettype none
module isc_core_tb;
  import isc_pkg::*;
  logic            clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]      s_axi_wstrb, instruction_phase_clocks;
  logic [1:0]      s_axi_bresp, s_axi_rresp, rsp_q;
  logic [PC_W-1:0] pm_addr;
  logic [IW-1:0]   pm_data;
  int              n_fail, total_checks;

  isc_core isc_core_i (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_addr, .pm_data,
    .instruction_phase_clocks);
  isc_pmem_model isc_pmem_model_i (.pm_addr, .pm_data);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for one handshake: 0 write take, 1 write answer, 2 read take, 3 read answer
  task automatic hs(input int k);
    logic s;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      s = k == 0 ? s_axi_awready & s_axi_wready : k == 1 ? s_axi_bvalid :
          k == 2 ? s_axi_arready : s_axi_rvalid;
      rd_q = s_axi_rdata;
      rsp_q = k == 1 ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (s === 1'b1) return;
    end
    n_fail++;
    $display("CHECK FAILED bus handshake expected 1 seen 0");
    results();
  endtask : hs

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    hs(1);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, rsp_q});
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string what);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs(2);
    s_axi_arvalid <= 1'b0;
    hs(3);
    s_axi_rready <= 1'b0;
    chk(what, ed, rd_q);
    chk("read response", {30'h0, er}, {30'h0, rsp_q});
    @(posedge clk);
  endtask : axi_rd

  function automatic logic [13:0] w(logic [2:0] c, logic [10:0] f);
    return {c, f};
  endfunction : w
  function automatic logic [13:0] imm(logic [7:0] v);
    return {CL_IMM, 3'h0, v};
  endfunction : imm
  function automatic logic [13:0] jump_instr(logic [9:0] t);
    return {CL_JMP, 1'b0, t};
  endfunction : jump_instr

  task automatic put(input logic [9:0] a, input logic [13:0] d);
    isc_pmem_model_i.mem[a] = d;
  endtask : put

  // Holds reset and fills program memory with no-operation words
  task automatic clr;
    nrst <= 1'b0;
    for (int a = 0; a < 1024; a++) put(a[9:0], NOP_WORD);
  endtask : clr

  task automatic core(input logic [11:0] e);
    axi_rd(CORE_OFF, {20'h0, e}, RESP_OKAY, "core state");
  endtask : core

  task automatic run(input int n, input logic [11:0] e);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (n) @(posedge clk);
    core(e);
  endtask : run

  task automatic t_regs;
    clr();
    run(8, 12'h000);
    axi_rd(CTRL_OFF, 32'h1, RESP_OKAY, "control after reset");
    axi_rd(8'h0C, 32'h0, RESP_SLVERR, "unmapped read");
    axi_wr(PC_OFF, 32'h3FF, RESP_OKAY);
    axi_wr(8'h0C, 32'h0, RESP_SLVERR);
  endtask : t_regs

  task automatic t_alu;
    logic [4:0]  op [15] = '{OP_ADD, OP_AND, OP_OR, OP_XOR, OP_CPL,
                             OP_INC, OP_DEC, OP_RR, OP_RL, OP_LD,
                             OP_SUB, OP_SBC, OP_DAA, OP_RRC, OP_RLC};
    logic [11:0] ex [15] = '{12'h24B, 12'h00C, 12'h03F, 12'h033, 12'h0C3,
                             12'h03D, 12'h03B, 12'h01E, 12'h078, 12'h03C,
                             12'h2D3, 12'h2D2, 12'h015, 12'h01E, 12'h078};
    for (int i = 0; i < 15; i++) begin
      clr();
      put(10'h000, imm(8'h3C));
      put(10'h001, w(CL_ALU, {OP_ST, 1'b1, 5'h08}));
      put(10'h002, imm(8'h0F));
      put(10'h003, w(CL_ALU, {op[i], 1'b0, 5'h08}));
      put(10'h004, jump_instr(10'h004));
      run(40, ex[i]);
    end
  endtask : t_alu

  task automatic t_skip;
    logic [2:0]  k  [3] = '{SK_SZ, SK_SNZ, SK_SZA};
    logic [11:0] ex [3] = '{12'h000, 12'h0EE, 12'h000};
    for (int i = 0; i < 3; i++) begin
      clr();
      put(10'h000, imm(8'h00));
      put(10'h001, w(CL_ALU, {OP_ST, 1'b1, 5'h09}));
      put(10'h002, w(CL_SKIP, {k[i], 3'h0, 5'h09}));
      put(10'h003, imm(8'hEE));
      put(10'h004, jump_instr(10'h004));
      run(40, ex[i]);
    end
  endtask : t_skip

  task automatic t_pcl;
    clr();
    put(10'h000, jump_instr(10'h100));
    put(10'h100, imm(8'h30));
    put(10'h101, w(CL_ALU, {OP_ST, 1'b1, DA_PCL}));
    put(10'h102, imm(8'hEE));
    put(10'h030, imm(8'hBB));
    put(10'h031, jump_instr(10'h031));
    put(10'h130, imm(8'h77));
    put(10'h131, jump_instr(10'h131));
    run(60, 12'h077);
  endtask : t_pcl

  task automatic t_stack;
    clr();
    put(10'h000, w(CL_CALL, 11'h010));
    put(10'h001, imm(8'h22));
    put(10'h002, jump_instr(10'h002));
    put(10'h010, w(CL_CALL, 11'h020));
    put(10'h011, w(CL_MISC, {MI_RET, 8'h00}));
    put(10'h020, w(CL_MISC, {MI_RET, 8'h00}));
    run(80, 12'h022);
    clr();
    put(10'h000, w(CL_CALL, 11'h010));
    put(10'h010, w(CL_CALL, 11'h020));
    put(10'h020, w(CL_CALL, 11'h030));
    put(10'h030, imm(8'h44));
    put(10'h031, jump_instr(10'h031));
    run(60, 12'h044);
  endtask : t_stack

  // Interrupt raised while two calls fill the stack, taken after the inner return
  task automatic t_irq;
    clr();
    put(10'h000, imm(8'h20));
    put(10'h001, w(CL_ALU, {OP_ST, 1'b1, 5'h0A}));
    put(10'h002, w(CL_CALL, 11'h010));
    put(10'h004, imm(8'h66));
    put(10'h005, jump_instr(10'h005));
    put(10'h010, w(CL_CALL, 11'h018));
    put(10'h012, jump_instr(10'h011));
    put(10'h018, w(CL_SKIP, {SK_SDZ, 3'h0, 5'h0A}));
    put(10'h019, jump_instr(10'h018));
    put(10'h01A, w(CL_MISC, {MI_RET, 8'h00}));
    run(60, 12'h020);
    axi_wr(CTRL_OFF, 32'h7, RESP_OKAY);
    repeat (100) @(posedge clk);
    core(12'h020);
    axi_rd(CTRL_OFF, 32'h7, RESP_OKAY, "request held");
    repeat (600) @(posedge clk);
    core(12'h066);
    axi_rd(CTRL_OFF, 32'h1, RESP_OKAY, "request taken");
  endtask : t_irq

  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    n_fail = 0;
    total_checks = 0;
    @(posedge clk);
    t_regs();
    t_alu();
    t_skip();
    t_pcl();
    t_stack();
    t_irq();
    results();
  end
endmodule : isc_core_tb
`default_nettype wire
